// ---- i2cms_pkg.sv ----
package i2cms_pkg;
    // Memory geometry
    localparam int ADDR_W = 17;
    localparam int MEM_DEPTH = 131072;
    localparam logic [16:0] ADDR_LAST = 17'h1FFFF;
    localparam logic [16:0] ADDR_RST = 17'h00000;
    // Slave address byte fields
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam int DTYPE_HI = 7;
    localparam int DTYPE_LO = 4;
    localparam int DSEL_HI = 3;
    localparam int DSEL_LO = 2;
    localparam int PAGE_BIT = 1;
    localparam int RW_BIT = 0;
    // Reserved identifiers
    localparam logic [7:0] RSV_ID = 8'hF8;
    localparam logic [7:0] SLEEP_CMD = 8'h86;
    // Bit counter landmarks
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Wake recovery, in core_clk cycles
    localparam logic [15:0] WAKE_REC_CYC_DEF = 16'h0010;

    // Link-side protocol states
    typedef enum logic [2:0] {
        LS_IDLE = 3'b000,
        LS_DEV = 3'b001,
        LS_ADRH = 3'b010,
        LS_ADRL = 3'b011,
        LS_WDAT = 3'b100,
        LS_RDAT = 3'b101,
        LS_RSV = 3'b110,
        LS_RBEG = 3'b111
    } i2cms_lst_t;

    // Core-side power states
    typedef enum logic [1:0] {
        CS_AWAKE = 2'b00,
        CS_ASLEEP = 2'b01,
        CS_WAKING = 2'b10
    } i2cms_cst_t;

    // Link-domain state held at falling SCL
    typedef struct packed {
        i2cms_lst_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [16:0] addr;
        logic page;
        logic [7:0] hi;
        logic oe;
        logic sdo;
        logic rsv;
        logic asleep;
        logic slp_tg;
        logic wak_tg;
        logic stt_ack;
        logic stp_ack;
        logic wp_s1;
        logic wp_s2;
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
        logic dn_s1;
        logic dn_s2;
    } i2cms_link_t;

    // All core-domain state
    typedef struct packed {
        i2cms_cst_t st;
        logic [15:0] cnt;
        logic slp_s1;
        logic slp_s2;
        logic slp_seen;
        logic wak_s1;
        logic wak_s2;
        logic wak_seen;
        logic done_tg;
        logic low_power;
    } i2cms_core_t;

    localparam i2cms_link_t LINK_RST = '0;
    localparam i2cms_core_t CORE_RST = '0;
endpackage

// ---- i2cms_top.sv ----
`timescale 1ns/100ps
// Overview of operation
// [R01] Write sends page bit plus two address bytes
// [R02] Address increments just before each acknowledge
// [R03] Address wraps from top to zero
// [R04] Current address held; reads start there
// [R05] Bursts of any length allowed
// [R06] Read: eight bits, then master ack decides
// [R07] All bytes shifted most significant bit first
// [R08] Direction bit zero selects write; bytes acked
// [R09] Byte commits at eighth bit only
// [R10] No write delay; always ready after write
// [R11] No page buffer; bytes written singly
// [R12] Protect high: no ack, no increment
// [R13] Protect low or undriven: unprotected
// [R14] Read address: drive data from current address
// [R15] Master ends reads by nack or condition
// [R16] Random read: address write, restart, read
// [R17] Sleep: reserved id, address, restart, command
// [R18] Only matching device acks reserved address byte
// [R19] Sleep begins at command acknowledge
// [R20] Asleep, own address wakes device
// [R21] Waking device nacks every access
// [R22] Address byte: type, select, page, direction
// [R23] Stop cancels operation in progress
// [R24] Start cancels and awaits new address
// [R25] Wake recovery is a cycle parameter
// [R26] Address latch starts at zero
module i2cms_top #(
    parameter logic [15:0] WAKE_REC_CYC = i2cms_pkg::WAKE_REC_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic wp_pin,
    input wire logic [1:0] dev_sel,
    output logic low_power
);
    import i2cms_pkg::*;

    i2cms_link_t lq; // Link state, falling SCL
    i2cms_link_t ld; // Its next value
    i2cms_core_t cq; // Core state
    i2cms_core_t cd; // Its next value
    logic [7:0] mem [0:MEM_DEPTH-1]; // Array
    logic stt_tg; // Toggles on each start
    logic stp_tg; // Toggles on each stop
    logic sda_smp; // Bit taken at rising SCL
    logic stt_p; // Start not yet handled
    logic stp_p; // Stop not yet handled
    logic busy; // Asleep or still waking
    logic mem_we; // Array write strobe
    logic [7:0] rx; // Byte with latest bit
    logic [7:0] rd_byte; // Byte at current address
    logic match; // Own type and select

    // Safe increment, wraps at the top
    function automatic logic [16:0] addr_next(input logic [16:0] a);
        addr_next = (a == ADDR_LAST) ? ADDR_RST : a + 17'h00001; // [R03]
    endfunction

    // Start: SDA falls while SCL is high
    always_ff @(negedge sda_i or posedge rst) begin
        if (rst) begin
            stt_tg <= 1'b0;
        end else if (scl_clk) begin
            stt_tg <= ~stt_tg;
        end
    end

    // Stop: SDA rises while SCL is high
    always_ff @(posedge sda_i or posedge rst) begin
        if (rst) begin
            stp_tg <= 1'b0;
        end else if (scl_clk) begin
            stp_tg <= ~stp_tg;
        end
    end

    // Data is stable while SCL is high
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            sda_smp <= 1'b1;
        end else begin
            sda_smp <= sda_i;
        end
    end

    // Conditions are seen at the next falling SCL
    assign stt_p = stt_tg != lq.stt_ack;
    assign stp_p = stp_tg != lq.stp_ack;
    assign busy = lq.asleep | (lq.wak_tg != lq.dn_s2);
    assign rx = {lq.sh[6:0], sda_smp}; // [R07]
    assign rd_byte = mem[lq.addr];
    assign match = (rx[DTYPE_HI:DTYPE_LO] == DEV_TYPE) &&
                   (rx[DSEL_HI:DSEL_LO] == lq.sel_s2); // [R22]

    // Link protocol, decided at falling SCL
    always_comb begin
        ld = lq;
        mem_we = 1'b0;
        ld.sdo = 1'b0;
        ld.wp_s1 = wp_pin;
        ld.wp_s2 = lq.wp_s1;
        ld.sel_s1 = dev_sel;
        ld.sel_s2 = lq.sel_s1;
        ld.dn_s1 = cq.done_tg;
        ld.dn_s2 = lq.dn_s1;
        if (stt_p || stp_p) begin
            // Condition aborts; no write has happened yet
            ld.stt_ack = stt_tg;
            ld.stp_ack = stp_tg;
            ld.cnt = BIT_FIRST;
            ld.oe = 1'b0;
            if (stt_p) begin
                ld.st = LS_DEV; // [R24]
            end else begin
                ld.st = LS_IDLE; // [R23]
                ld.rsv = 1'b0;
            end
        end else begin
            case (lq.st)
                LS_IDLE: begin
                    // Ignore the bus until a start
                    ld.oe = 1'b0;
                end
                LS_RBEG: begin
                    // First read bit right after our ack
                    ld.sh = rd_byte; // [R14]
                    ld.oe = ~rd_byte[7];
                    ld.cnt = BIT_FIRST;
                    ld.st = LS_RDAT;
                end
                LS_RDAT: begin
                    if (lq.cnt == BIT_ACK) begin
                        if (!sda_smp) begin
                            // Master acked: next byte
                            ld.sh = rd_byte; // [R06]
                            ld.oe = ~rd_byte[7];
                            ld.cnt = BIT_FIRST;
                        end else begin
                            // Nack ends the read
                            ld.oe = 1'b0; // [R06]
                            ld.st = LS_IDLE;
                        end
                    end else if (lq.cnt == BIT_LAST) begin
                        // Release for master ack, bump address
                        ld.oe = 1'b0;
                        ld.addr = addr_next(lq.addr); // [R02]
                        ld.cnt = BIT_ACK;
                    end else begin
                        // Open drain: drive only for zero
                        ld.sh = {lq.sh[6:0], 1'b0}; // [R07]
                        ld.oe = ~lq.sh[6];
                        ld.cnt = lq.cnt + 4'h1;
                    end
                end
                default: begin
                    if (lq.cnt == BIT_ACK) begin
                        // End of acknowledge slot
                        ld.oe = 1'b0;
                        ld.cnt = BIT_FIRST;
                    end else if (lq.cnt != BIT_LAST) begin
                        ld.sh = rx;
                        ld.cnt = lq.cnt + 4'h1;
                    end else begin
                        // Eighth bit is in
                        ld.sh = rx;
                        ld.cnt = BIT_ACK;
                        ld.oe = 1'b0;
                        ld.st = LS_IDLE;
                        case (lq.st)
                            LS_DEV: begin
                                ld.rsv = 1'b0;
                                if (rx == RSV_ID) begin
                                    if (!busy) begin
                                        ld.oe = 1'b1; // [R17]
                                        ld.st = LS_RSV;
                                    end
                                end else if (rx == SLEEP_CMD && lq.rsv && !busy) begin
                                    // Sleep from this ack on
                                    ld.oe = 1'b1; // [R19]
                                    ld.asleep = 1'b1;
                                    ld.slp_tg = ~lq.slp_tg;
                                end else if (match && lq.asleep) begin
                                    // Own address wakes; still nacked
                                    ld.asleep = 1'b0; // [R20]
                                    ld.wak_tg = ~lq.wak_tg;
                                end else if (match && !busy) begin
                                    ld.oe = 1'b1; // [R21]
                                    if (rx[RW_BIT]) begin
                                        ld.st = LS_RBEG; // [R04]
                                    end else begin
                                        ld.page = rx[PAGE_BIT]; // [R08]
                                        ld.st = LS_ADRH;
                                    end
                                end
                            end
                            LS_RSV: begin
                                // Low two bits are ignored here
                                if (match) begin
                                    ld.oe = 1'b1; // [R18]
                                    ld.rsv = 1'b1;
                                end
                            end
                            LS_ADRH: begin
                                ld.hi = rx;
                                ld.oe = 1'b1;
                                ld.st = LS_ADRL;
                            end
                            LS_ADRL: begin
                                // Full address latched at once
                                ld.addr = {lq.page, lq.hi, rx}; // [R01]
                                ld.oe = 1'b1; // [R16]
                                ld.st = LS_WDAT;
                            end
                            LS_WDAT: begin
                                if (!lq.wp_s2) begin // [R12]
                                    // Unprotected: commit now
                                    mem_we = 1'b1; // [R13]
                                    ld.addr = addr_next(lq.addr); // [R02]
                                    ld.oe = 1'b1; // [R08]
                                    ld.st = LS_WDAT; // [R05]
                                end
                            end
                            default: begin
                                ld.st = LS_IDLE;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // Link register; SCL stops between frames
    always_ff @(negedge scl_clk or posedge rst) begin
        if (rst) begin
            lq <= LINK_RST; // [R26]
        end else begin
            lq <= ld;
        end
    end

    // One byte per write, no staging buffer
    always_ff @(negedge scl_clk) begin
        if (mem_we) begin
            mem[lq.addr] <= rx; // [R09] [R11] [R10]
        end
    end

    // Core side: sleep indication and wake timer
    always_comb begin
        cd = cq;
        cd.slp_s1 = lq.slp_tg;
        cd.slp_s2 = cq.slp_s1;
        cd.slp_seen = cq.slp_s2;
        cd.wak_s1 = lq.wak_tg;
        cd.wak_s2 = cq.wak_s1;
        cd.wak_seen = cq.wak_s2;
        case (cq.st)
            CS_AWAKE, CS_ASLEEP: begin
                // Wake beats sleep if both seen at once
                if (cq.wak_s2 != cq.wak_seen) begin
                    cd.st = CS_WAKING;
                    cd.cnt = WAKE_REC_CYC - 16'h0001; // [R25]
                    cd.low_power = 1'b1;
                end else if (cq.slp_s2 != cq.slp_seen) begin
                    cd.st = CS_ASLEEP;
                    cd.low_power = 1'b1;
                end
            end
            CS_WAKING: begin
                if (cq.cnt == 16'h0000) begin
                    // Ready; link stops nacking
                    cd.done_tg = cq.wak_s2; // [R21]
                    cd.st = CS_AWAKE;
                    cd.low_power = 1'b0;
                end else begin
                    cd.cnt = cq.cnt - 16'h0001;
                end
            end
            default: begin
                cd.st = CS_AWAKE;
            end
        endcase
    end

    // Core register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cq <= CORE_RST;
        end else begin
            cq <= cd;
        end
    end

    assign sda_o = lq.sdo;
    assign sda_oe = lq.oe;
    assign low_power = cq.low_power;

    property p_wrap;
        @(negedge scl_clk) disable iff (rst)
        (lq.st == LS_WDAT && lq.cnt == BIT_LAST && !lq.wp_s2 && !stt_p && !stp_p
         && lq.addr == ADDR_LAST) |=> (lq.addr == ADDR_RST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("address did not wrap"); // [R03]

    property p_wp_block;
        @(negedge scl_clk) disable iff (rst)
        (lq.st == LS_WDAT && lq.cnt == BIT_LAST && lq.wp_s2 && !stt_p && !stp_p)
        |=> (!lq.oe && $stable(lq.addr));
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("protected write acked"); // [R12]

    property p_wr_inc;
        @(negedge scl_clk) disable iff (rst)
        (mem_we && lq.addr != ADDR_LAST)
        |=> (lq.addr == $past(lq.addr) + 17'h00001) && lq.oe ##1 !lq.oe;
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("write ack or increment wrong"); // [R02]
    property p_start;
        @(negedge scl_clk) disable iff (rst)
        stt_p |=> (lq.st == LS_DEV && lq.cnt == BIT_FIRST && !lq.oe);
    endproperty
    a_start: assert property (p_start) else $error("start did not restart"); // [R24]
    property p_stop;
        @(negedge scl_clk) disable iff (rst)
        (stp_p && !stt_p) |=> (lq.st == LS_IDLE && !lq.oe && !mem_we);
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not cancel"); // [R23]
    property p_busy_nack;
        @(negedge scl_clk) disable iff (rst)
        (lq.st == LS_DEV && lq.cnt == BIT_LAST && busy && !stt_p && !stp_p)
        |=> !lq.oe;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("acked while waking"); // [R21]

    property p_rd_end;
        @(negedge scl_clk) disable iff (rst)
        (lq.st == LS_RDAT && lq.cnt == BIT_ACK && sda_smp && !stt_p && !stp_p)
        |=> (lq.st == LS_IDLE && !lq.oe) ##1 !lq.oe;
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("read went on after nack"); // [R06]

    property p_rd_step;
        @(negedge scl_clk) disable iff (rst)
        (lq.st == LS_RDAT && lq.cnt == BIT_LAST && !stt_p && !stp_p)
        |=> (!lq.oe && lq.addr == addr_next($past(lq.addr)));
    endproperty
    a_rd_step: assert property (p_rd_step) else $error("read step wrong"); // [R14]

    property p_sleep;
        @(negedge scl_clk) disable iff (rst)
        (lq.st == LS_DEV && lq.cnt == BIT_LAST && rx == SLEEP_CMD && lq.rsv && !busy
         && !stt_p && !stp_p) |=> (lq.oe && lq.asleep) ##1 !lq.oe;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong"); // [R19]

    property p_wake_done;
        @(posedge core_clk) disable iff (rst)
        (cq.st == CS_WAKING && cq.cnt == 16'h0000)
        |=> (cq.st == CS_AWAKE && !cq.low_power && cq.done_tg == $past(cq.wak_s2));
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("wake end wrong"); // [R25]
endmodule

// ---- i2cms_master.sv ----
`timescale 1ns/100ps
// Bus master model: makes the link clock and pulls the data wire low
module i2cms_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam int Q = 8; // Quarter of the 32 ns link period

    // Clock idles high between frames; data wire released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start or repeated start; releases data first so a restart works too
    task automatic start();
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask

    // Stop, leaving the clock standing high
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask

    // Top n bits of a byte; data changes only while clock is low
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            #Q sda_low = !b[i];
            #Q scl = 1'b1;
            #(2 * Q) scl = 1'b0;
        end
    endtask

    // Whole byte, then hand the wire over for the acknowledge
    task automatic write_byte(input logic [7:0] b, output logic ack);
        send_bits(b, 8);
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q ack = !sda;
        #Q scl = 1'b0;
    endtask

    // Byte from the device; more high asks for the next byte
    task automatic read_byte(input logic more, output logic [7:0] b);
        b = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            #Q sda_low = 1'b0;
            #Q scl = 1'b1;
            #Q b[i] = sda;
            #Q scl = 1'b0;
        end
        #Q sda_low = more;
        #Q scl = 1'b1;
        #(2 * Q) scl = 1'b0;
    endtask
endmodule

// ---- test_i2c_serial_memory_slave.sv ----
`timescale 1ns/100ps
module test_i2c_serial_memory_slave;
    import i2cms_pkg::*;
    localparam logic [1:0] SEL = 2'h2; // Our address pins
    logic core_clk = 1'b0;
    logic rst = 1'b0; // Raised after time zero so the link flops see an edge
    logic wp_pin = 1'b0; // Undriven pin reads as low
    logic [1:0] dev_sel = SEL;
    logic sda_o;
    logic sda_oe;
    logic low_power;
    logic scl;
    logic m_low;
    wire sda;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;

    always #20 core_clk = !core_clk;

    // Open-drain wire with pull-up
    assign sda = !(m_low || (sda_oe && !sda_o));

    i2cms_master partner (.scl(scl), .sda_low(m_low), .sda(sda));

    // Short wake recovery keeps the run brief
    i2cms_top #(.WAKE_REC_CYC(16'h0002)) dut (
        .core_clk(core_clk), .rst(rst), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .wp_pin(wp_pin), .dev_sel(dev_sel), .low_power(low_power));

    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard in core cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end

    function automatic logic [7:0] hdr(input logic page, input logic rd);
        return {DEV_TYPE, SEL, page, rd};
    endfunction

    // One byte out, acknowledge compared
    task automatic wr(input logic [7:0] b, input logic exp);
        logic k;
        partner.write_byte(b, k);
        check("ack", k, exp);
    endtask

    // Write header plus both address bytes
    task automatic set_addr(input logic [16:0] a);
        partner.start();
        wr(hdr(a[16], 1'b0), 1'b1);
        wr(a[15:8], 1'b1);
        wr(a[7:0], 1'b1);
    endtask

    // Start and read header
    task automatic rd_open();
        partner.start();
        wr(hdr(1'b0, 1'b1), 1'b1);
    endtask

    task automatic rd(input logic [7:0] exp, input logic more);
        logic [7:0] d;
        partner.read_byte(more, d);
        check("read data", d, exp);
    endtask

    // Burst across the top of the array, then selective and current reads
    task automatic t_wrap();
        set_addr(17'h1FFFE);
        wr(8'hA1, 1'b1);
        wr(8'hB2, 1'b1);
        wr(8'hC3, 1'b1);
        wr(8'hD4, 1'b1);
        partner.stop();
        set_addr(17'h1FFFE);
        rd_open();
        rd(8'hA1, 1'b1);
        rd(8'hB2, 1'b1);
        rd(8'hC3, 1'b0);
        partner.stop();
        rd_open();
        rd(8'hD4, 1'b0);
        partner.stop();
    endtask

    // Foreign select and foreign type are refused
    task automatic t_select();
        partner.start();
        wr({DEV_TYPE, ~SEL, 2'b00}, 1'b0);
        partner.stop();
        partner.start();
        wr({4'h5, SEL, 2'b00}, 1'b0);
        partner.stop();
    endtask

    // Protected write is refused and leaves the address put
    task automatic t_protect();
        set_addr(17'h00010);
        wr(8'h77, 1'b1);
        partner.stop();
        @(posedge core_clk);
        #1 wp_pin = 1'b1;
        set_addr(17'h00010);
        wr(8'h55, 1'b0);
        partner.stop();
        @(posedge core_clk);
        #1 wp_pin = 1'b0;
        rd_open();
        rd(8'h77, 1'b0);
        partner.stop();
    endtask

    // Partial bytes cut by start and by stop never reach the array
    task automatic t_abort();
        set_addr(17'h00020);
        wr(8'h11, 1'b1);
        partner.stop();
        set_addr(17'h00020);
        partner.send_bits(8'hEE, 5);
        rd_open();
        rd(8'h11, 1'b0);
        partner.stop();
        set_addr(17'h00020);
        partner.send_bits(8'hEE, 6);
        partner.stop();
        // Lone clock after the stop: the cut byte must be dropped here
        partner.send_bits(8'hFF, 1);
        rd_open();
        rd(8'h11, 1'b0);
        partner.stop();
    endtask

    task automatic wait_lp(input logic v);
        for (int i = 0; i < 60 && low_power !== v; i++)
            @(posedge core_clk);
        check("low_power", low_power, v);
    endtask

    // Sleep entry, refused wake-up access to the sleeping device, acknowledge polling
    task automatic t_sleep();
        logic k;
        partner.start();
        wr(RSV_ID, 1'b1);
        wr({DEV_TYPE, ~SEL, 2'b00}, 1'b0);
        partner.stop();
        partner.start();
        wr(SLEEP_CMD, 1'b0);
        partner.stop();
        partner.start();
        wr(RSV_ID, 1'b1);
        wr({DEV_TYPE, SEL, 2'b11}, 1'b1);
        partner.start();
        wr(SLEEP_CMD, 1'b1);
        wait_lp(1'b1);
        partner.start();
        wr(hdr(1'b0, 1'b1), 1'b0);
        partner.stop();
        k = 1'b0;
        for (int i = 0; i < 20 && k !== 1'b1; i++) begin
            partner.start();
            partner.write_byte(hdr(1'b0, 1'b0), k);
            partner.stop();
        end
        check("wake ack", k, 1'b1);
        wait_lp(1'b0);
    endtask

    initial begin
        #1 rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check("oe in reset", sda_oe, 1'b0);
        check("low_power in reset", low_power, 1'b0);
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        @(posedge core_clk);
        #1;
        t_wrap();
        t_select();
        t_protect();
        t_abort();
        t_sleep();
        wrap_up();
    end
endmodule
